// ==== common/lpmc_defines.vh ====
// Purpose: shared constants for the low power mode controller
// Assumes: apb word registers, byte addresses
// Notes:   offsets and reset values are local choices
`ifndef LPMC_DEFINES_VH
`define LPMC_DEFINES_VH
// ==========================================================
// register offsets
`define LPMC_OFF_STBY      12'h000
`define LPMC_OFF_DSTBY     12'h004
`define LPMC_OFF_SNZ       12'h008
`define LPMC_OFF_WUP0      12'h00C
`define LPMC_OFF_WUP1      12'h010
`define LPMC_OFF_ELS       12'h014
`define LPMC_OFF_CKDIV     12'h018
`define LPMC_OFF_MSTOP     12'h01C
`define LPMC_OFF_OPC       12'h020
`define LPMC_OFF_SEC       12'h024
`define LPMC_OFF_STAT      12'h028
`define LPMC_OFF_IMASK     12'h02C
`define LPMC_OFF_MODE      12'h030
// ==========================================================
// field positions and widths
`define LPMC_DIV_W         3
`define LPMC_OPC_HIGH      2'h0
`define LPMC_OPC_LOW       2'h1
`define LPMC_OPC_SUB       2'h2
`define LPMC_ST_OSC        0
`define LPMC_ST_WAKE       1
`define LPMC_ST_SECERR     2
`define LPMC_ST_W          3
// ==========================================================
// reset values
`define LPMC_RST_MSTOP     32'hFFFFFFFF
`define LPMC_RST_SEC       16'hFFFF
// ==========================================================
// timing: oscillator silence before stop is flagged
`define LPMC_OSC_TMO_NS    1000
`define LPMC_CLK_NS        10
`define LPMC_OSC_TMO_CYC   (`LPMC_OSC_TMO_NS / `LPMC_CLK_NS)
`endif

// ==== verilog/lpmc_osc_mon.v ====
// Purpose: main oscillator stop detector
// Assumes: osc_in is asynchronous to pclk
// Notes:   flags stop when no edge is seen within the timeout
`timescale 1ns/1ns
`include "lpmc_defines.vh"
module lpmc_osc_mon #(
	parameter TMO = `LPMC_OSC_TMO_CYC
) (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// oscillator
	input  wire        osc_in,
	input  wire        enable,
	// result
	output reg         stopped
);
	reg        sync_a;
	reg        sync_b;
	reg        prev;
	reg [15:0] cnt;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a  <= 1'b0;
			sync_b  <= 1'b0;
			prev    <= 1'b0;
			cnt     <= 16'h0000;
			stopped <= 1'b0;
		end else begin
			sync_a <= osc_in;
			sync_b <= sync_a;
			prev   <= sync_b;
			// any edge restarts the watch
			if (!enable || (sync_b != prev)) begin
				cnt     <= 16'h0000;
				stopped <= 1'b0;
			end else if (cnt == TMO[15:0] - 16'h0001) begin
				stopped <= 1'b1;
			end else begin
				cnt <= cnt + 16'h0001;
			end
		end
	end
endmodule // lpmc_osc_mon

// ==== verilog/lpmc_ctrl.v ====
// Purpose: low power mode controller with apb register file
// Assumes: wfi, snooze and interrupt inputs are on pclk
// Notes:   resets are the chip reset presetn plus reset_req input
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "lpmc_defines.vh"
// What this block does
// - wfi enters sleep if standby select clear, else software standby unless deep
// - wfi with standby select and deep standby set enters deep software standby
// - snooze trigger moves software standby to snooze only when snooze enabled
// - sleep ends on nmi, any interrupt, or available reset
// - software standby ends on nmi, wakeup-enabled interrupt, or reset
// - snooze ends on nmi or interrupt chosen by event link and wakeup enable
// - interrupt exit resumes program, except deep standby exit goes to reset
// - reset exit from any low power mode always enters reset state
// - separate divider ratio for system, four peripheral and flash clocks
// - one stop bit per peripheral module, affecting that module alone
// - three operating power modes: high, low and sub-oscillator speed
// - stopped main oscillator raises oscillation stop interrupt
// - per-register secure attribute filters non-secure accesses
module lpmc_ctrl #(
	parameter NMOD    = 32,
	parameter OSC_TMO = `LPMC_OSC_TMO_CYC
) (
	// apb
	input  wire         pclk,
	input  wire         presetn,
	input  wire         psel,
	input  wire         penable,
	input  wire         pwrite,
	input  wire [11:0]  paddr,
	input  wire [31:0]  pwdata,
	input  wire         pprot_ns,
	output wire         pready,
	output reg  [31:0]  prdata,
	output wire         pslverr,
	// core and interrupt controller
	input  wire         wfi,
	input  wire         snooze_req,
	input  wire         nmi,
	input  wire [63:0]  irq,
	input  wire         reset_req,
	input  wire         osc_in,
	// power state outputs
	output reg          core_stop,
	output reg          clk_stop,
	output reg          deep_pd,
	output reg          resume_irq,
	output reg          reset_out,
	output reg  [17:0]  clk_div,
	output wire [NMOD-1:0] module_stop,
	output wire [1:0]   power_control_mode,
	output wire         osc_stop_irq,
	output wire         irq_out
);
	// ==========================================================
	// states
	localparam S_RUN   = 6'b000001;
	localparam S_ENTER = 6'b000010;
	localparam S_SLEEP = 6'b000100;
	localparam S_STANDBY_SELECT_BIT  = 6'b001000;
	localparam S_SNZ   = 6'b010000;
	localparam S_DEEP  = 6'b100000;

	// ==========================================================
	// registers
	reg        standby_select_bit;
	reg        deep_standby_bit;
	reg        snooze_enable_bit;
	reg [31:0] wakeup_interrupt_enable_0;
	reg [31:0] wakeup_interrupt_enable_1;
	reg [63:0] event_link_setting_reg;
	reg [NMOD-1:0] mstop;
	reg [1:0]  opc;
	reg [15:0] sec_attr;
	reg [`LPMC_ST_W-1:0] status;
	reg [`LPMC_ST_W-1:0] imask;
	reg [5:0]  state;
	reg [5:0]  next_state;
	reg        osc_dly;
	wire       osc_stopped;

	// register index from address, used by the secure filter
	function [3:0] reg_idx;
		input [11:0] a;
		begin
			reg_idx = a[5:2];
		end
	endfunction

	wire        acc      = psel & penable;
	wire [3:0]  idx      = reg_idx(paddr);
	wire        mapped   = (paddr <= `LPMC_OFF_MODE) && (paddr[1:0] == 2'b00);
	wire        sec_self = (paddr == `LPMC_OFF_SEC);
	wire        sec_bad  = mapped & pprot_ns & (sec_attr[idx] | sec_self);
	wire        wr       = acc & pwrite & mapped & ~sec_bad;
	wire [63:0] wup      = {wakeup_interrupt_enable_1, wakeup_interrupt_enable_0};
	wire        any_irq  = |irq;
	wire        wake_sby = nmi | (|(irq & wup));
	wire        wake_snz = nmi | (|(irq & wup & event_link_setting_reg));

	// ==========================================================
	// mode decode, shared by the entry and wake paths
	// which low power mode a wfi asks for
	function [5:0] entry_mode;
		input sel;
		input deep;
		begin
			if (!sel)
				entry_mode = S_SLEEP;
			else if (!deep)
				entry_mode = S_STANDBY_SELECT_BIT;
			else
				entry_mode = S_DEEP;
		end
	endfunction

	// wake sources of each mode; deep standby shares the standby list
	function mode_wake;
		input [5:0] s;
		begin
			case (s)
			S_SLEEP: mode_wake = nmi | any_irq;
			S_STANDBY_SELECT_BIT:  mode_wake = wake_sby;
			S_SNZ:   mode_wake = wake_snz;
			S_DEEP:  mode_wake = wake_sby;
			default: mode_wake = 1'b0;
			endcase
		end
	endfunction

	wire [5:0]  entry_sel = entry_mode(standby_select_bit, deep_standby_bit);

	assign pready  = 1'b1;
	assign pslverr = acc & (~mapped | sec_bad);
	assign module_stop = mstop;
	assign power_control_mode = opc;

	// ==========================================================
	// oscillator watch
	lpmc_osc_mon #(
		.TMO     (OSC_TMO)
	) u_osc (
		.pclk    (pclk),
		.presetn (presetn),
		.osc_in  (osc_in),
		.enable  (1'b1),
		.stopped (osc_stopped)
	);
	assign osc_stop_irq = status[`LPMC_ST_OSC] & imask[`LPMC_ST_OSC];
	assign irq_out = |(status & imask);

	// ==========================================================
	// register writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			standby_select_bit        <= 1'b0;
			deep_standby_bit          <= 1'b0;
			snooze_enable_bit         <= 1'b0;
			wakeup_interrupt_enable_0 <= 32'h00000000;
			wakeup_interrupt_enable_1 <= 32'h00000000;
			event_link_setting_reg    <= 64'h0000000000000000;
			clk_div                   <= 18'h00000;
			mstop                     <= {NMOD{1'b1}};
			opc                       <= `LPMC_OPC_HIGH;
			sec_attr                  <= `LPMC_RST_SEC;
			imask                     <= {`LPMC_ST_W{1'b0}};
		end else if (wr) begin
			case (paddr)
			`LPMC_OFF_STBY:  standby_select_bit <= pwdata[0];
			`LPMC_OFF_DSTBY: deep_standby_bit <= pwdata[0];
			`LPMC_OFF_SNZ:   snooze_enable_bit <= pwdata[0];
			`LPMC_OFF_WUP0:  wakeup_interrupt_enable_0 <= pwdata;
			`LPMC_OFF_WUP1:  wakeup_interrupt_enable_1 <= pwdata;
			`LPMC_OFF_ELS: begin
				// one word selects the low 32 sources, mirrored high
				event_link_setting_reg <= {pwdata, pwdata};
			end
			`LPMC_OFF_CKDIV: clk_div <= pwdata[17:0];
			`LPMC_OFF_MSTOP: mstop <= pwdata[NMOD-1:0];
			`LPMC_OFF_OPC: begin
				// code 3 is not a mode and is ignored
				if (pwdata[1:0] != 2'h3)
					opc <= pwdata[1:0];
			end
			`LPMC_OFF_SEC: begin
				if (!pprot_ns)
					sec_attr <= pwdata[15:0];
			end
			`LPMC_OFF_IMASK: imask <= pwdata[`LPMC_ST_W-1:0];
			default: ;
			endcase
		end
	end

	// ==========================================================
	// sticky status, set wins over write-one-to-clear
	wire [`LPMC_ST_W-1:0] st_set;
	wire [`LPMC_ST_W-1:0] st_clr;
	assign st_set = {acc & sec_bad, resume_irq, osc_stopped & ~osc_dly};
	assign st_clr = (wr && paddr == `LPMC_OFF_STAT) ? pwdata[`LPMC_ST_W-1:0]
		: {`LPMC_ST_W{1'b0}};
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status  <= {`LPMC_ST_W{1'b0}};
			osc_dly <= 1'b0;
		end else begin
			osc_dly <= osc_stopped;
			status  <= (status & ~st_clr) | st_set;
		end
	end

	// ==========================================================
	// read mux
	always @* begin
		prdata = 32'h00000000;
		if (acc && !pwrite && mapped && !sec_bad) begin
			case (paddr)
			`LPMC_OFF_STBY:  prdata = {31'h00000000, standby_select_bit};
			`LPMC_OFF_DSTBY: prdata = {31'h00000000, deep_standby_bit};
			`LPMC_OFF_SNZ:   prdata = {31'h00000000, snooze_enable_bit};
			`LPMC_OFF_WUP0:  prdata = wakeup_interrupt_enable_0;
			`LPMC_OFF_WUP1:  prdata = wakeup_interrupt_enable_1;
			`LPMC_OFF_ELS:   prdata = event_link_setting_reg[31:0];
			`LPMC_OFF_CKDIV: prdata = {14'h0000, clk_div};
			`LPMC_OFF_MSTOP: prdata = mstop;
			`LPMC_OFF_OPC:   prdata = {30'h00000000, opc};
			`LPMC_OFF_SEC:   prdata = {16'h0000, sec_attr};
			`LPMC_OFF_STAT:  prdata = {29'h00000000, status};
			`LPMC_OFF_IMASK: prdata = {29'h00000000, imask};
			`LPMC_OFF_MODE:  prdata = {26'h0000000, state};
			default:         prdata = 32'h00000000;
			endcase
		end
	end

	// ==========================================================
	// mode state machine
	always @* begin
		next_state = state;
		case (state)
		S_RUN: begin
			if (wfi)
				next_state = S_ENTER;
		end
		S_ENTER: begin
			// wake during entry abandons it, so no wake event is lost
			if (mode_wake(entry_sel))
				next_state = S_RUN;
			else
				next_state = entry_sel;
		end
		S_SLEEP: begin
			if (mode_wake(state))
				next_state = S_RUN;
		end
		S_STANDBY_SELECT_BIT: begin
			if (mode_wake(state))
				next_state = S_RUN;
			else if (snooze_req && snooze_enable_bit)
				next_state = S_SNZ;
		end
		S_SNZ: begin
			if (mode_wake(state))
				next_state = S_RUN;
		end
		S_DEEP: begin
			if (mode_wake(state))
				next_state = S_RUN;
		end
		default: next_state = S_RUN;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state      <= S_RUN;
			core_stop  <= 1'b0;
			clk_stop   <= 1'b0;
			deep_pd    <= 1'b0;
			resume_irq <= 1'b0;
			reset_out  <= 1'b0;
		end else if (reset_req) begin
			// a reset ends any mode in the reset state
			state      <= S_RUN;
			core_stop  <= 1'b0;
			clk_stop   <= 1'b0;
			deep_pd    <= 1'b0;
			resume_irq <= 1'b0;
			reset_out  <= 1'b1;
		end else begin
			state      <= next_state;
			core_stop  <= (next_state != S_RUN);
			clk_stop   <= (next_state == S_STANDBY_SELECT_BIT) | (next_state == S_DEEP);
			deep_pd    <= (next_state == S_DEEP);
			// leaving deep standby is a reset, the rest resume
			resume_irq <= (next_state == S_RUN) & (state != S_RUN) & (state != S_DEEP)
				& (state != S_ENTER | nmi | any_irq);
			reset_out  <= (next_state == S_RUN) & (state == S_DEEP);
		end
	end
endmodule // lpmc_ctrl

// ==== sim/lpmc_core_model.sv ====
// Purpose: core and interrupt controller stand-in for lpmc_ctrl
// Assumes: requests change just after a rising pclk edge
// Notes:   a stopped oscillator freezes at its last level, like a dead crystal
`timescale 1ns/1ns
// ==========================================================
// core model
module lpmc_core_model (
	// clock
	input  wire         pclk,
	// requests toward the controller
	output logic        wfi = 0,
	output logic        snooze_req = 0,
	output logic        nmi = 0,
	output logic [63:0] irq = '0,
	output logic        reset_req = 0,
	output logic        osc_in = 0
);
	logic osc_run = 1;
	always @(posedge pclk) if (osc_run) osc_in <= ~osc_in;
	// k bits: 0 wfi, 1 snooze, 2 nmi, 3 irq[n], 4 reset; held len cycles
	task evt(input logic [4:0] k, input int n, input int len);
		@(posedge pclk);
		{reset_req, nmi, snooze_req, wfi} <= {k[4], k[2], k[1], k[0]};
		irq <= k[3] ? 64'h1 << n : '0;
		repeat (len) @(posedge pclk);
		{reset_req, nmi, snooze_req, wfi} <= '0;
		irq <= '0;
	endtask
endmodule // lpmc_core_model

// ==== sim/lpmc_ctrl_chk.sv ====
// Purpose: port assertions for lpmc_ctrl
// Assumes: zero-wait apb, one-cycle mode steps
// Notes:   bound to every lpmc_ctrl instance
`timescale 1ns/1ns
`include "lpmc_defines.vh"
// ==========================================================
// checker
module lpmc_ctrl_chk (
	// clock, reset and apb
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire        pprot_ns,
	input wire        pslverr,
	// core side
	input wire        wfi,
	input wire        nmi,
	input wire        reset_req,
	input wire        core_stop,
	input wire        clk_stop,
	input wire        deep_pd,
	input wire        resume_irq,
	input wire        reset_out,
	input wire        osc_stop_irq,
	input wire        irq_out
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_WFI_ENTER: assert property (!core_stop && wfi && !reset_req |=> core_stop)
		else $error("wfi did not stop the core");
	AST_CLK_CORE: assert property (clk_stop |-> core_stop)
		else $error("clock stop without core stop");
	AST_DEEP_CLK: assert property (deep_pd |-> clk_stop && core_stop)
		else $error("deep standby without clock stop");
	AST_NMI_WAKE: assert property (core_stop && nmi && !reset_req |=> !core_stop)
		else $error("nmi did not wake");
	AST_RESUME: assert property (core_stop && $past(core_stop) && !deep_pd && nmi && !reset_req
		|=> resume_irq)
		else $error("wake without resume pulse");
	AST_DEEP_EXIT: assert property (deep_pd && $past(core_stop) && nmi && !reset_req
		|=> reset_out && !resume_irq)
		else $error("deep exit did not reset");
	AST_PULSE: assert property (resume_irq |=> !resume_irq)
		else $error("resume pulse too long");
	AST_RESET_EXIT: assert property (core_stop && reset_req |=> reset_out && !core_stop)
		else $error("reset did not end low power");
	AST_OSC: assert property (osc_stop_irq |-> irq_out)
		else $error("oscillator interrupt not on irq_out");
	AST_SEC: assert property (psel && penable && pwrite && pprot_ns && paddr == `LPMC_OFF_SEC
		|-> pslverr)
		else $error("non-secure write to attributes accepted");
	AST_UNMAP: assert property (psel && penable && paddr > `LPMC_OFF_MODE |-> pslverr)
		else $error("unmapped access accepted");
	cover property (deep_pd ##1 reset_out);
	cover property (clk_stop && !deep_pd ##1 resume_irq);
	cover property (osc_stop_irq);
endmodule // lpmc_ctrl_chk
bind lpmc_ctrl lpmc_ctrl_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pprot_ns, .pslverr, .wfi, .nmi, .reset_req, .core_stop, .clk_stop, .deep_pd,
	.resume_irq, .reset_out, .osc_stop_irq, .irq_out);

// ==== sim/tb.sv ====
// Purpose: directed apb and mode tests for lpmc_ctrl
// Assumes: zero-wait apb, oscillator timeout shortened to 8
// Notes:   the MODE encoding is opaque, so snooze is seen as a change
`timescale 1ns/1ns
`include "lpmc_defines.vh"
// ==========================================================
// bench
module tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pprot_ns = 0, err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, rd, m1;
	wire         pready, pslverr, wfi, snooze_req, nmi, reset_req, osc_in, core_stop, clk_stop;
	wire         deep_pd, resume_irq, reset_out, osc_stop_irq, irq_out;
	wire [63:0]  irq;
	wire [31:0]  prdata, module_stop;
	wire [17:0]  clk_div;
	wire [1:0]   power_control_mode;
	int          miscompares = 0, samples_checked = 0, cyc = 0;
	always #5 pclk = ~pclk;
	lpmc_core_model core (.pclk(pclk), .wfi(wfi), .snooze_req(snooze_req), .nmi(nmi), .irq(irq),
		.reset_req(reset_req), .osc_in(osc_in));
	lpmc_ctrl #(.NMOD(32), .OSC_TMO(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot_ns(pprot_ns),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .wfi(wfi), .snooze_req(snooze_req),
		.nmi(nmi), .irq(irq), .reset_req(reset_req), .osc_in(osc_in), .core_stop(core_stop),
		.clk_stop(clk_stop), .deep_pd(deep_pd), .resume_irq(resume_irq), .reset_out(reset_out),
		.clk_div(clk_div), .module_stop(module_stop), .power_control_mode(power_control_mode),
		.osc_stop_irq(osc_stop_irq), .irq_out(irq_out));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// hangs are cut here; the tests need well under 2000 cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			wrap_up();
		end
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ns);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata, pprot_ns} <= {2'b10, w, a, d, ns};
		@(posedge pclk);
		penable <= 1;
		// only the bench timeout ends a wait for the answer
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
		#1;
	endtask
	task tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		chk(module_stop, 32'hFFFFFFFF);
		apb(0, `LPMC_OFF_SEC, 0, 0);
		chk(rd, 32'h0000FFFF);
		// dividers go in before the slower power modes are picked
		apb(1, `LPMC_OFF_CKDIV, 32'h00031A2B, 0);
		chk(32'(clk_div), 32'h00031A2B);
		apb(1, `LPMC_OFF_MSTOP, 32'h00000005, 0);
		chk(module_stop, 32'h00000005);
		for (int i = 0; i < 3; i++) begin
			apb(1, `LPMC_OFF_OPC, i, 0);
			chk(32'(power_control_mode), i);
		end
		// code 3 names no mode and must leave the sub-oscillator setting alone
		apb(1, `LPMC_OFF_OPC, 3, 0);
		chk(32'(power_control_mode), 2);
		apb(1, `LPMC_OFF_SEC, 0, 1);
		chk(32'(err), 1);
		apb(0, 12'h034, 0, 0);
		chk(32'(err), 1);
		$display("test registers done");
		apb(1, `LPMC_OFF_STBY, 0, 0);
		core.evt(5'h01, 0, 1);
		tick(1);
		chk({core_stop, clk_stop}, 2'b10);
		core.evt(5'h08, 5, 1);
		tick(0);
		chk({resume_irq, core_stop}, 2'b10);
		$display("test sleep done");
		apb(1, `LPMC_OFF_WUP0, 32'h00000080, 0);
		apb(1, `LPMC_OFF_STBY, 1, 0);
		core.evt(5'h01, 0, 1);
		tick(1);
		chk({clk_stop, deep_pd}, 2'b10);
		core.evt(5'h08, 5, 1);
		tick(0);
		chk(32'(core_stop), 1);
		core.evt(5'h08, 7, 1);
		tick(0);
		chk(32'(resume_irq), 1);
		$display("test standby done");
		core.evt(5'h01, 0, 1);
		tick(1);
		apb(0, `LPMC_OFF_MODE, 0, 0);
		m1 = rd;
		chk(32'(m1 != 32'h00000000), 1);
		core.evt(5'h02, 0, 1);
		tick(1);
		apb(0, `LPMC_OFF_MODE, 0, 0);
		chk(rd, m1);
		apb(1, `LPMC_OFF_SNZ, 1, 0);
		core.evt(5'h02, 0, 1);
		tick(1);
		apb(0, `LPMC_OFF_MODE, 0, 0);
		chk(32'(rd !== m1), 1);
		core.evt(5'h04, 0, 1);
		tick(0);
		chk(32'(resume_irq), 1);
		$display("test snooze done");
		apb(1, `LPMC_OFF_DSTBY, 1, 0);
		core.evt(5'h01, 0, 1);
		tick(1);
		chk(32'(deep_pd), 1);
		core.evt(5'h04, 0, 1);
		tick(0);
		chk({reset_out, resume_irq}, 2'b10);
		apb(1, `LPMC_OFF_DSTBY, 0, 0);
		apb(1, `LPMC_OFF_STBY, 0, 0);
		core.evt(5'h05, 0, 2);
		tick(1);
		chk(32'(core_stop), 0);
		core.evt(5'h01, 0, 1);
		tick(1);
		core.evt(5'h10, 0, 1);
		tick(0);
		chk({reset_out, core_stop}, 2'b10);
		$display("test deep and reset done");
		apb(1, `LPMC_OFF_IMASK, 1, 0);
		core.osc_run <= 0;
		tick(20);
		chk({osc_stop_irq, irq_out}, 2'b11);
		core.osc_run <= 1;
		tick(10);
		apb(1, `LPMC_OFF_STAT, 1, 0);
		tick(1);
		chk(32'(osc_stop_irq), 0);
		$display("test oscillator done");
		wrap_up();
	end
endmodule // tb
